/* src/host_port_device.sv */
// device end of the byte-wide host port: decodes host cycles into
// register strobes or internal memory, drives reads, pulls interrupt
// assumes host pins already synchronous to clk_sys
`timescale 1ns/1ns

// Behaviour
// - chip select high means ignore bus
// - chip select rising ends the access
// - direction low writes, high reads
// - output enable grounded in direction-line style
// - write strobe rising ends strobe-style write
// - drive read data while read strobe low
// - eleven-bit address picks register or memory
// - byte bus, device drives only reads
// - pull interrupt low while anything pending
module host_port_device
#(
  parameter int IRQ_W = 4 // number of internal interrupt sources
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  host_port_if.device bus,
  input wire host_port_pkg::style_e busStyle,
  input wire logic [IRQ_W-1:0] irqPending,
  output logic regWr,
  output logic regRd,
  output logic [host_port_pkg::ADDR_W-1:0] regAddr,
  output logic [host_port_pkg::DATA_W-1:0] regWrData,
  input wire logic [host_port_pkg::DATA_W-1:0] regRdData
);
  import host_port_pkg::*;

  // ==========================================================
  // access state
  typedef enum logic [1:0]
  {
    ST_IDLE,  // waiting for a selected cycle
    ST_WRITE, // write in progress, capturing data
    ST_READ   // read in progress, driving data
  } state_e;

  state_e state;              // current access state
  state_e next_state;         // next access state
  logic [ADDR_W-1:0] accAddr; // address latched at cycle start
  logic [DATA_W-1:0] accData; // latest write data seen
  logic [DATA_W-1:0] memByte; // memory byte fetched for a read
  logic fetched;              // read data already loaded
  logic [DATA_W-1:0] mem [MEM_DEPTH]; // internal memory positions

  // ==========================================================
  // pin decode
  // nothing below looks at the bus unless chip select is low
  wire selected = bus.csN == PIN_LOW;
  wire strobeStyle = busStyle == STYLE_STROBES;
  // oe is deliberately not looked at in direction-line style,
  // since the host holds it grounded there
  wire readReq = strobeStyle ? (bus.oeN == PIN_LOW)
                             : (bus.rwN == PIN_HIGH);
  wire writeReq = bus.rwN == PIN_LOW;
  wire startWrite = selected && writeReq && !readReq;
  wire startRead = selected && readReq && !writeReq;

  // a write ends on chip select rising, or on write strobe rising
  wire writeEnd = !selected || (strobeStyle && !writeReq);
  // a read ends on chip select rising or when its request drops
  wire readEnd = !selected || !readReq;

  // ==========================================================
  // address decode
  wire memHit = bus.addr[MEM_SEL_BIT];
  wire accMem = accAddr[MEM_SEL_BIT];
  wire [MEM_AW-1:0] memIdx = bus.addr[MEM_AW-1:0];
  wire [MEM_AW-1:0] accIdx = accAddr[MEM_AW-1:0];
  wire commitWrite = state == ST_WRITE && writeEnd;
  wire loadRead = state == ST_READ && !fetched && !readEnd;
  wire driveRead = state == ST_READ && !readEnd;
  wire [DATA_W-1:0] readByte = accMem ? memByte : regRdData;

  // ==========================================================
  // next state
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        // direction is fixed for the whole cycle once picked
        if (startWrite)
          next_state = ST_WRITE;
        else if (startRead)
          next_state = ST_READ;
      end
      ST_WRITE:
      begin
        // end of strobe or select closes the write
        if (writeEnd)
          next_state = ST_IDLE;
      end
      ST_READ:
      begin
        // end of strobe or select releases the bus
        if (readEnd)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ==========================================================
  // address and write data capture
  // data is taken every cycle of the write, so the last value
  // before the closing edge is the one that lands
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      accAddr <= '0;
      accData <= DATA_RST;
    end
    else if (state == ST_IDLE && (startWrite || startRead))
    begin
      accAddr <= bus.addr;
      accData <= bus.dataBus;
    end
    else if (state == ST_WRITE && !writeEnd)
      accData <= bus.dataBus;
  end

  // ==========================================================
  // internal memory, written only when a write closes
  always_ff @(posedge clk_sys)
  begin
    if (commitWrite && accMem)
      mem[accIdx] <= accData;
  end

  // memory read fetched on the cycle a read starts
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      memByte <= DATA_RST;
    else if (state == ST_IDLE && startRead && memHit)
      memByte <= mem[memIdx];
  end

  // ==========================================================
  // register side strobes, one cycle each
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      regWr <= 1'b0;
      regRd <= 1'b0;
      regAddr <= '0;
      regWrData <= DATA_RST;
    end
    else
    begin
      // register write lands only after the cycle is closed
      regWr <= commitWrite && !accMem;
      regRd <= state == ST_IDLE && startRead && !memHit;
      if (state == ST_IDLE && (startWrite || startRead))
        regAddr <= bus.addr;
      if (commitWrite)
        regWrData <= accData;
    end
  end

  // ==========================================================
  // read data drive
  // data appears two cycles after select and strobe are seen:
  // one to fetch, one to load the pin register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      fetched <= 1'b0;
      bus.devOut <= DATA_RST;
      bus.devOeN <= PIN_HIGH;
    end
    else
    begin
      if (loadRead)
        bus.devOut <= readByte;
      fetched <= driveRead && (fetched || loadRead);
      // released as soon as strobe or select goes high
      bus.devOeN <= !(driveRead && (fetched || loadRead));
    end
  end

  // ==========================================================
  // interrupt pin, open drain
  // the output level is always low; only the enable moves
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      bus.irqOut <= PIN_LOW;
      bus.irqOeN <= PIN_HIGH;
    end
    else
    begin
      bus.irqOut <= PIN_LOW;
      bus.irqOeN <= !(|irqPending);
    end
  end

endmodule

/* src/host_port_host.sv */
// host end of the byte-wide host port: turns user commands into
// processor bus cycles in either bus style
// assumes the device samples the pins on the same clk_sys
`timescale 1ns/1ns
module host_port_host
(
  input wire logic clk_sys,
  input wire logic rst_n,
  host_port_if.host bus,
  input wire host_port_pkg::style_e busStyle,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [host_port_pkg::ADDR_W-1:0] cmdAddr,
  input wire logic [host_port_pkg::DATA_W-1:0] cmdData,
  output logic cmdReady,
  output logic rspValid,
  output logic [host_port_pkg::DATA_W-1:0] rspData,
  output logic irqSeen
);
  import host_port_pkg::*;

  // ==========================================================
  // cycle sequencer
  typedef enum logic [2:0]
  {
    H_IDLE,   // waiting for a command
    H_ACTIVE, // select and strobe low
    H_END,    // strobe released, select may still be low
    H_REC     // everything released, one recovery cycle
  } hstate_e;

  hstate_e state;      // current phase
  hstate_e next_state; // next phase
  logic [3:0] cnt;     // cycles left in the active phase
  logic isWrite;       // direction of current cycle

  wire strobeStyle = busStyle == STYLE_STROBES;
  wire take = state == H_IDLE && cmdValid;
  wire lastActive = state == H_ACTIVE && cnt == CNT_ONE;

  // ==========================================================
  // next phase
  always_comb
  begin
    next_state = state;
    case (state)
      H_IDLE:
        if (cmdValid)
          next_state = H_ACTIVE;
      H_ACTIVE:
        if (lastActive)
          next_state = H_END;
      H_END:
        next_state = H_REC;
      H_REC:
        next_state = H_IDLE;
      default:
        next_state = H_IDLE;
    endcase
  end

  // ==========================================================
  // phase and counter
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state <= H_IDLE;
      cnt <= CNT_ZERO;
      isWrite <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (take)
      begin
        cnt <= STROBE_CNT;
        isWrite <= cmdWrite;
      end
      else if (state == H_ACTIVE)
        cnt <= cnt - CNT_ONE;
    end
  end

  // ==========================================================
  // bus pins
  // in strobe style the strobe rises a cycle before select, so
  // the device sees the write end by its strobe
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      bus.csN <= PIN_HIGH;
      bus.rwN <= PIN_HIGH;
      // grounded from reset on in direction-line style, never toggled
      bus.oeN <= strobeStyle ? PIN_HIGH : PIN_LOW;
      bus.addr <= '0;
      bus.hostOut <= DATA_RST;
      bus.hostOeN <= PIN_HIGH;
    end
    else if (take)
    begin
      bus.csN <= PIN_LOW;
      bus.addr <= cmdAddr;
      bus.hostOut <= cmdData;
      bus.hostOeN <= !cmdWrite;
      bus.rwN <= !cmdWrite;
      // grounded for the whole direction-line style
      bus.oeN <= strobeStyle ? cmdWrite : PIN_LOW;
    end
    else if (state == H_ACTIVE && lastActive)
    begin
      bus.rwN <= PIN_HIGH;
      bus.oeN <= strobeStyle ? PIN_HIGH : PIN_LOW;
      if (!strobeStyle)
        bus.csN <= PIN_HIGH;
    end
    else if (state == H_END)
    begin
      bus.csN <= PIN_HIGH;
      bus.hostOeN <= PIN_HIGH;
    end
  end

  // ==========================================================
  // user side answers
  // read data is taken on the last active cycle, while the
  // device still drives it
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cmdReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= DATA_RST;
      irqSeen <= 1'b0;
    end
    else
    begin
      cmdReady <= next_state == H_IDLE && !take;
      rspValid <= lastActive && !isWrite;
      if (lastActive && !isWrite)
        rspData <= bus.dataBus;
      irqSeen <= bus.irqN == PIN_LOW;
    end
  end

endmodule

/* src/host_port_if.sv */
// the pins between the host processor and the device port
// assumes both ends share clk_sys; resolves shared lines from enables
`timescale 1ns/1ns
interface host_port_if;
  import host_port_pkg::*;

  // ==========================================================
  // host driven pins
  logic csN;                  // chip select, active low
  logic rwN;                  // direction line or write strobe
  logic oeN;                  // output enable or read strobe
  logic [ADDR_W-1:0] addr;    // address
  logic [DATA_W-1:0] hostOut; // host data out
  logic hostOeN;              // host data enable, low drives

  // ==========================================================
  // device driven pins
  logic [DATA_W-1:0] devOut; // device data out
  logic devOeN;              // device data enable, low drives
  logic irqOut;              // open-drain level, always low
  logic irqOeN;              // interrupt enable, low pulls down

  // ==========================================================
  // resolved wire levels, pull-ups where nobody drives
  wire [DATA_W-1:0] dataBus = !devOeN ? devOut :
                              (!hostOeN ? hostOut : BUS_FLOAT);
  wire irqN = !irqOeN ? irqOut : PIN_HIGH;

  modport device
  (
    input csN, rwN, oeN, addr, dataBus,
    output devOut, devOeN, irqOut, irqOeN
  );

  modport host
  (
    output csN, rwN, oeN, addr, hostOut, hostOeN,
    input dataBus, irqN
  );
endinterface

/* src/host_port_pkg.sv */
// shared constants and types for the byte-wide host processor port
// assumes both ends run on one 20 MHz system clock
package host_port_pkg;

  // ==========================================================
  // bus widths
  localparam int ADDR_W = 11;      // host address width
  localparam int DATA_W = 8;       // host data width

  // ==========================================================
  // address map split
  localparam int MEM_SEL_BIT = 10; // high half is internal memory
  localparam int MEM_DEPTH = 1024; // internal memory bytes
  localparam int MEM_AW = 10;      // internal memory address width

  // ==========================================================
  // pin levels and reset values
  localparam logic PIN_LOW = 1'b0;  // active level of every strobe
  localparam logic PIN_HIGH = 1'b1; // idle level of every strobe
  localparam logic [7:0] DATA_RST = 8'h00; // data register reset
  localparam logic [7:0] BUS_FLOAT = 8'hFF; // pulled-up undriven bus

  // ==========================================================
  // host timing, in nanoseconds and clock cycles
  localparam int CLK_PERIOD_NS = 50;  // system clock period
  localparam int STROBE_MIN_NS = 200; // least strobe low time
  localparam int STROBE_CYCLES =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYCLES);
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // ==========================================================
  // bus style selection
  typedef enum logic
  {
    STYLE_RW_LINE,  // one direction line, output enable grounded
    STYLE_STROBES   // separate read and write strobes
  } style_e;

endpackage

/* testbench/byte_wide_host_bus_port_test.sv */
// self-checking bench: host and device ends joined by the pin interface,
// plus a lone device on a second interface driven here out of spec
// assumes the package, interface and both ends are compiled first
`timescale 1ns/1ns
module byte_wide_host_bus_port_test;
  import host_port_pkg::*;
  // ==========================================================
  // clock, reset and user side stimulus
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  style_e busStyle = STYLE_RW_LINE; // static, changed only in reset
  logic cmdValid = 1'b0;
  logic cmdWrite = 1'b0;
  logic [ADDR_W-1:0] cmdAddr = '0;
  logic [DATA_W-1:0] cmdData = '0;
  logic [3:0] irqPending = 4'h0;
  logic cmdReady, rspValid, irqSeen, regWr, regRd, badWr, badRd;
  logic [DATA_W-1:0] rspData, regWrData;
  logic [ADDR_W-1:0] regAddr;
  int fail_count = 0;
  int n_tests = 0;
  int badHits = 0; // strobes from the lone device
  always #25 clk_sys = ~clk_sys;
  host_port_if bus();
  host_port_if badBus();
  // register stand-in: read data is a fixed scramble of the address
  wire [DATA_W-1:0] regRdData = regAddr[7:0] ^ 8'h5A;

  // ==========================================================
  // design ends and checker
  host_port_device host_port_device_i
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .busStyle(busStyle),
    .irqPending(irqPending), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData)
  );
  host_port_host host_port_host_i
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .busStyle(busStyle),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .irqSeen(irqSeen)
  );
  // lone device, fed by the bench so rules can be broken on purpose
  host_port_device bad_host_port_device_i
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(badBus), .busStyle(STYLE_RW_LINE),
    .irqPending(4'h0), .regWr(badWr), .regRd(badRd), .regAddr(),
    .regWrData(), .regRdData(8'h00)
  );
  host_port_assertions host_port_assertions_i
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .csN(bus.csN), .rwN(bus.rwN), .oeN(bus.oeN),
    .addr(bus.addr), .hostOeN(bus.hostOeN), .devOut(bus.devOut), .devOeN(bus.devOeN),
    .irqOut(bus.irqOut), .irqOeN(bus.irqOeN)
  );
  // pre-edge sample, so no race with the strobe flops
  always @(posedge clk_sys)
    if (badWr === 1'b1 || badRd === 1'b1)
      badHits++;

  // ==========================================================
  // verdict, compare and bounded waits
  task automatic test_done();
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chkVal(input string what, input logic [10:0] exp, input logic [10:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang();
    chkVal("wait bound", 11'h000, 11'h001);
    test_done();
  endtask
  // one user command, launched once the host is idle
  task automatic issue(input logic wr, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (cmdReady !== 1'b1)
    begin
      n++;
      if (n > 20)
        hang();
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdAddr <= a;
    cmdData <= d;
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    @(negedge clk_sys);
  endtask
  // write: pin levels in the first selected cycle, then the commit
  task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic toReg);
    logic hit;
    hit = 1'b0;
    issue(1'b1, a, d);
    chkVal("write direction", 11'h000, 11'(bus.rwN));
    chkVal("enable pin", 11'(busStyle == STYLE_STROBES), 11'(bus.oeN));
    chkVal("write pins", 11'(d), 11'(bus.dataBus));
    repeat (8)
    begin
      @(negedge clk_sys);
      if (regWr === 1'b1)
      begin
        hit = 1'b1;
        chkVal("write address", a, regAddr);
        chkVal("write data", 11'(d), 11'(regWrData));
      end
    end
    chkVal("register strobe", 11'(toReg), 11'(hit));
    chkVal("deselected after", 11'h001, 11'(bus.csN));
  endtask
  // read: pins, device drive and the returned byte
  task automatic rd(input logic [10:0] a, input logic [7:0] exp, input logic toReg);
    logic hit;
    logic [7:0] onBus;
    int n;
    hit = 1'b0;
    onBus = 8'h00;
    n = 0;
    issue(1'b0, a, 8'h00);
    chkVal("read direction", 11'h001, 11'(bus.rwN));
    chkVal("read strobe", 11'h000, 11'(bus.oeN));
    while (rspValid !== 1'b1)
    begin
      if (bus.devOeN === 1'b0)
        onBus = bus.dataBus;
      if (regRd === 1'b1)
        hit = 1'b1;
      n++;
      if (n > 10)
        hang();
      @(negedge clk_sys);
    end
    chkVal("read pins", 11'(exp), 11'(onBus));
    chkVal("read data", 11'(exp), 11'(rspData));
    chkVal("register read", 11'(toReg), 11'(hit));
  endtask

  // ==========================================================
  // main sequence, once per bus style
  initial
  begin
    badBus.csN = 1'b1;
    badBus.rwN = 1'b1;
    badBus.oeN = 1'b1;
    badBus.addr = 11'h005;
    badBus.hostOut = 8'h99;
    badBus.hostOeN = 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      @(posedge clk_sys);
      rst_n <= 1'b0;
      busStyle <= style_e'(s);
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      chkVal("idle enable", 11'(busStyle == STYLE_STROBES), 11'(bus.oeN));
      wr(11'h012, 8'hC3, 1'b1);
      wr(11'h7FF, 8'h3C, 1'b0);
      wr(11'h400, 8'hA5, 1'b0);
      rd(11'h7FF, 8'h3C, 1'b0);
      rd(11'h400, 8'hA5, 1'b0);
      rd(11'h3FF, 8'hA5, 1'b1);
      rd(11'h000, 8'h5A, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
        @(posedge clk_sys);
        irqPending <= 4'(1 << i);
        repeat (4) @(negedge clk_sys);
        chkVal("interrupt pin", 11'h000, 11'(bus.irqN));
        chkVal("interrupt seen", 11'h001, 11'(irqSeen));
      end
      @(posedge clk_sys);
      irqPending <= 4'h0;
      repeat (4) @(negedge clk_sys);
      chkVal("interrupt released", 11'h001, 11'(bus.irqN));
      chkVal("interrupt seen off", 11'h000, 11'(irqSeen));
    end
    // strobes and data driven while deselected: device must stay quiet
    @(posedge clk_sys);
    badBus.rwN <= 1'b0;
    badBus.hostOeN <= 1'b0;
    repeat (6) @(negedge clk_sys);
    // then a read request, still deselected: no strobe, no drive
    @(posedge clk_sys);
    badBus.hostOeN <= 1'b1;
    badBus.rwN <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chkVal("deselected strobes", 11'h000, 11'(badHits));
    chkVal("deselected drive", 11'h001, 11'(badBus.devOeN));
    // enable left high in direction-line style: the read still happens
    @(posedge clk_sys);
    badBus.csN <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chkVal("ungrounded read", 11'h000, 11'(badBus.devOeN));
    @(posedge clk_sys);
    badBus.csN <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chkVal("read released", 11'h001, 11'(badBus.devOeN));
    test_done();
  end
endmodule

/* testbench/host_port_assertions.sv */
// pin-level checker for the host port, beside the joining interface
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ns
module host_port_assertions
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic rwN,
  input wire logic oeN,
  input wire logic [host_port_pkg::ADDR_W-1:0] addr,
  input wire logic hostOeN,
  input wire logic [host_port_pkg::DATA_W-1:0] devOut,
  input wire logic devOeN,
  input wire logic irqOut,
  input wire logic irqOeN
);
  import host_port_pkg::*;
  // ==========================================================
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // selection and cycle end
  cs_ignore_a: assert property (csN |=> devOeN)
    else $error("device drives while deselected");
  cs_bounded_a: assert property ($fell(csN) |-> ##[3:6] csN)
    else $error("chip select cycle not ended in time");
  strobe_end_a: assert property ($rose(rwN) && !csN |=> csN)
    else $error("write strobe end not followed by deselect");
  addr_hold_a: assert property (!csN && !$past(csN) |-> $stable(addr))
    else $error("address moved inside a cycle");

  // ==========================================================
  // direction and data bus ownership
  write_quiet_a: assert property (!csN && !rwN |=> devOeN)
    else $error("device drives during a write");
  read_source_a: assert property ($fell(devOeN) |-> !$past(csN, 2) && $past(rwN, 2))
    else $error("device drive without a read two cycles back");
  read_hold_a: assert property (!devOeN && !csN && rwN && !oeN |=> !devOeN)
    else $error("read data dropped while read still held");
  bus_excl_a: assert property (!devOeN |-> hostOeN)
    else $error("both ends drive the data bus");
  data_steady_a: assert property (!devOeN ##1 !devOeN |-> $stable(devOut))
    else $error("read data changed while driven");

  // ==========================================================
  // open-drain interrupt only ever pulls low
  irq_pull_a: assert property (!irqOeN |-> !irqOut)
    else $error("interrupt pin driven high");

  // main scenarios reached
  cov_read: cover property ($fell(devOeN));
  cov_strobe_write: cover property ($rose(rwN) && !csN);
  cov_irq: cover property ($fell(irqOeN));
endmodule
